// >>> hw/boundary_scan_test_port.sv
// Boundary-scan test access port with pin control, config load and probe access
`timescale 1ns/100ps
module boundary_scan_test_port #(
  parameter int NPINS = 8,
  parameter int LA_W = 16,
  parameter logic [31:0] IDCODE = scan_port_pkg::IDCODE_RST,
  parameter logic [31:0] USERCODE = scan_port_pkg::USERCODE_RST
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic scan_clk_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic tdo_oe_n_out,
  input wire scan_port_pkg::cfg_status_t cfg_status_in,
  input wire logic [NPINS-1:0] user_out_in,
  input wire logic [NPINS-1:0] user_oe_in,
  input wire logic [NPINS-1:0] pin_in,
  output logic [NPINS-1:0] pin_out,
  output logic [NPINS-1:0] pin_oe_n_out,
  output logic [NPINS*scan_port_pkg::IOSTD_W-1:0] io_std_out,
  input wire logic [LA_W-1:0] la_data_in,
  output logic [scan_port_pkg::CFG_W-1:0] cfg_byte_out,
  output logic cfg_valid_out,
  output logic cfg_abort_out
);
  import scan_port_pkg::*;
  localparam int BSR_W = 3 * NPINS;
  localparam int IOS_W = NPINS * IOSTD_W;
  localparam int XW = BSR_W + LA_W + 2;

  // ---------------- Scan clock domain ----------------
  tap_state_t state;
  tap_state_t next_state;
  logic [IR_W-1:0] ir_sh;
  logic [IR_W-1:0] instr;
  logic bypass;
  logic [ID_W-1:0] id_sh;
  logic [BSR_W-1:0] bsr_sh;
  logic [BSR_W-1:0] bsr_upd;
  logic [IOS_W-1:0] ios_sh;
  logic [IOS_W-1:0] ios_upd;
  logic [LA_W-1:0] la_sh;
  logic [CFG_W-1:0] cfg_sh;
  logic [1:0][CFG_W-1:0] cfg_pair;
  logic [2:0] cfg_cnt;
  logic cfg_tgl;
  logic upd_tgl;
  logic [XW-1:0] x_sync;
  logic tap_rst;
  logic [BSR_W-1:0] bsr_view;
  logic [LA_W-1:0] la_view;
  logic busy_view;
  logic tdo_next;

  // Core-side values brought into the scan domain
  level_sync #(.W(XW)) u_to_scan (
    .clock_in(scan_clk_in),
    .rst_in(1'b0),
    .ce_in(1'b1),
    .async_in({rst_in, cfg_status_in.busy, la_data_in, pin_in, user_out_in, user_oe_in}),
    .sync_out(x_sync)
  );
  assign tap_rst = x_sync[XW-1];
  assign busy_view = x_sync[XW-2];
  assign la_view = x_sync[BSR_W +: LA_W];
  // Capture layout by field: output enables lowest, output values next, input values highest
  assign bsr_view = x_sync[BSR_W-1:0];

  always_comb begin
    next_state = state;
    case (state)
      TLR: next_state = tms_in ? TLR : RTI;
      RTI: next_state = tms_in ? SEL_DR : RTI;
      SEL_DR: next_state = tms_in ? SEL_IR : CAP_DR;
      CAP_DR: next_state = tms_in ? EX1_DR : SH_DR;
      SH_DR: next_state = tms_in ? EX1_DR : SH_DR;
      EX1_DR: next_state = tms_in ? UPD_DR : PA_DR;
      PA_DR: next_state = tms_in ? EX2_DR : PA_DR;
      EX2_DR: next_state = tms_in ? UPD_DR : SH_DR;
      UPD_DR: next_state = tms_in ? SEL_DR : RTI;
      SEL_IR: next_state = tms_in ? TLR : CAP_IR;
      CAP_IR: next_state = tms_in ? EX1_IR : SH_IR;
      SH_IR: next_state = tms_in ? EX1_IR : SH_IR;
      EX1_IR: next_state = tms_in ? UPD_IR : PA_IR;
      PA_IR: next_state = tms_in ? EX2_IR : PA_IR;
      EX2_IR: next_state = tms_in ? UPD_IR : SH_IR;
      UPD_IR: next_state = tms_in ? SEL_DR : RTI;
      default: next_state = TLR;
    endcase
  end

  // TAP state register
  always_ff @(posedge scan_clk_in) begin
    if (tap_rst) begin
      state <= TLR;
    end else begin
      state <= next_state;
    end
  end

  // Ten-bit instruction register, idcode after logic reset
  always_ff @(posedge scan_clk_in) begin
    if (tap_rst || state == TLR) begin
      ir_sh <= IR_CAPTURE;
      instr <= OP_IDCODE;
    end else if (state == CAP_IR) begin
      ir_sh <= IR_CAPTURE;
    end else if (state == SH_IR) begin
      ir_sh <= {tdi_in, ir_sh[IR_W-1:1]};
    end else if (state == UPD_IR) begin
      instr <= ir_sh;
    end
  end

  // Bypass bit, also the default path for unlisted codes
  always_ff @(posedge scan_clk_in) begin
    if (state == CAP_DR) begin
      bypass <= 1'b0;
    end else if (state == SH_DR) begin
      bypass <= tdi_in;
    end
  end

  // Idcode and usercode share one 32-bit shifter
  always_ff @(posedge scan_clk_in) begin
    if (state == CAP_DR) begin
      // Lowest idcode bit forced to one, usercode loaded unchanged
      id_sh <= (instr == OP_USERCODE) ? USERCODE : {IDCODE[ID_W-1:1], 1'b1};
    end else if (state == SH_DR) begin
      id_sh <= {tdi_in, id_sh[ID_W-1:1]};
    end
  end

  // Boundary register capture, shift and update
  always_ff @(posedge scan_clk_in) begin
    if (tap_rst) begin
      bsr_upd <= '0;
    end else if (instr == OP_SAMPLE || instr == OP_EXTEST) begin
      if (state == CAP_DR) begin
        // Pin states captured into the boundary register
        bsr_sh <= bsr_view;
      end else if (state == SH_DR) begin
        bsr_sh <= {tdi_in, bsr_sh[BSR_W-1:1]};
      end else if (state == UPD_DR) begin
        bsr_upd <= bsr_sh;
      end
    end
  end

  // I/O standard chain, usable before or during user mode
  always_ff @(posedge scan_clk_in) begin
    if (tap_rst) begin
      ios_upd <= {NPINS{IOSTD_RST}};
    end else if (instr == OP_CONFIG_IO) begin
      if (state == CAP_DR) begin
        ios_sh <= ios_upd;
      end else if (state == SH_DR) begin
        ios_sh <= {tdi_in, ios_sh[IOS_W-1:1]};
      end else if (state == UPD_DR) begin
        ios_upd <= ios_sh;
      end
    end
  end

  // Probe data captured and shifted out
  always_ff @(posedge scan_clk_in) begin
    if (state == CAP_DR) begin
      la_sh <= la_view;
    end else if (state == SH_DR) begin
      la_sh <= {tdi_in, la_sh[LA_W-1:1]};
    end
  end

  // Bitstream bits gathered into bytes, each handed over by a toggle
  always_ff @(posedge scan_clk_in) begin
    if (tap_rst) begin
      cfg_cnt <= '0;
      cfg_tgl <= 1'b0;
      cfg_pair <= '0;
    end else if (instr != OP_CFG_LOAD || state == CAP_DR) begin
      cfg_cnt <= '0;
    end else if (state == SH_DR) begin
      cfg_sh <= {tdi_in, cfg_sh[CFG_W-1:1]};
      cfg_cnt <= cfg_cnt + 3'h1;
      if (cfg_cnt == 3'h7) begin
        // Alternate slots, so a byte stands two byte times while the core fetches it
        cfg_pair[!cfg_tgl] <= {tdi_in, cfg_sh[CFG_W-1:1]};
        cfg_tgl <= ~cfg_tgl;
      end
    end
  end

  // Update toggle tells the core that instruction or boundary words changed
  always_ff @(posedge scan_clk_in) begin
    if (tap_rst) begin
      upd_tgl <= 1'b0;
    end else if (state == UPD_DR || state == UPD_IR || (state == TLR && instr != OP_IDCODE)) begin
      upd_tgl <= ~upd_tgl;
    end
  end

  // Serial output select, unlisted codes fall to bypass
  always_comb begin
    tdo_next = bypass;
    if (state == SH_IR) begin
      tdo_next = ir_sh[0];
    end else begin
      case (instr)
        OP_IDCODE, OP_USERCODE: tdo_next = id_sh[0];
        OP_SAMPLE, OP_EXTEST: tdo_next = bsr_sh[0];
        OP_CONFIG_IO: tdo_next = ios_sh[0];
        OP_LA_ACCESS: tdo_next = la_sh[0];
        OP_CFG_LOAD: tdo_next = cfg_sh[0];
        default: tdo_next = bypass;
      endcase
    end
  end

  // Serial output changes on the falling edge, driven only while shifting
  always_ff @(negedge scan_clk_in) begin
    if (tap_rst) begin
      tdo_out <= 1'b0;
      tdo_oe_n_out <= 1'b1;
    end else begin
      tdo_out <= tdo_next;
      tdo_oe_n_out <= !(state == SH_DR || state == SH_IR);
    end
  end

  // ---------------- Core clock domain ----------------
  logic [1:0] tgl_sync;
  logic [1:0] tgl_seen;
  logic [IR_W-1:0] core_instr;
  logic [BSR_W-1:0] core_bsr;
  pin_mode_t mode;

  // Toggles from the scan domain
  level_sync #(.W(2)) u_to_core (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .async_in({cfg_tgl, upd_tgl}),
    .sync_out(tgl_sync)
  );

  // Words are stable in the scan domain once their toggle has crossed
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      tgl_seen <= '0;
      core_instr <= OP_IDCODE;
      core_bsr <= '0;
      io_std_out <= {NPINS{IOSTD_RST}};
      cfg_byte_out <= '0;
      cfg_valid_out <= 1'b0;
    end else if (ce_in) begin
      tgl_seen <= tgl_sync;
      cfg_valid_out <= tgl_sync[1] ^ tgl_seen[1];
      if (tgl_sync[1] ^ tgl_seen[1]) begin
        cfg_byte_out <= cfg_pair[tgl_sync[1]];
      end
      if (tgl_sync[0] ^ tgl_seen[0]) begin
        core_instr <= instr;
        core_bsr <= bsr_upd;
        io_std_out <= ios_upd;
      end
    end
  end

  // Boundary drive modes gated off while configuration runs
  always_comb begin
    mode.from_bsr = !cfg_status_in.busy && (core_instr == OP_EXTEST || core_instr == OP_CLAMP);
    mode.all_hiz = !cfg_status_in.busy && core_instr == OP_HIGHZ;
  end

  // Config-io instruction holds the configuration engine in reset
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cfg_abort_out <= 1'b0;
    end else if (ce_in && core_instr == OP_CONFIG_IO) begin
      cfg_abort_out <= 1'b1;
    end
  end

  // Pin drivers; boundary drive bits per pin: [3i+1] data, [3i+2] enable; captured values sit by field, not per pin
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pin_out <= '0;
      pin_oe_n_out <= '1;
    end else if (ce_in) begin
      for (int i = 0; i < NPINS; i++) begin
        if (mode.all_hiz) begin
          pin_out[i] <= 1'b0;
          pin_oe_n_out[i] <= 1'b1;
        end else if (mode.from_bsr) begin
          // Extest and clamp drive from the boundary register
          pin_out[i] <= core_bsr[3*i+1];
          pin_oe_n_out[i] <= !core_bsr[3*i+2];
        end else if (cfg_status_in.power_good && cfg_status_in.done) begin
          pin_out[i] <= user_out_in[i];
          pin_oe_n_out[i] <= !user_oe_in[i];
        end else begin
          pin_out[i] <= 1'b0;
          pin_oe_n_out[i] <= 1'b1;
        end
      end
    end
  end
endmodule

// >>> hw/level_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module level_sync #(
  parameter int W = 1
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // Stage chain; only s2 reads s1
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else if (ce_in) begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Per-bit acceptance once the two later stages agree
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sync_out <= '0;
    end else if (ce_in) begin
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          sync_out[i] <= s3[i];
        end
      end
    end
  end
endmodule

// >>> hw/scan_port_pkg.sv
// Shared constants, states and carriers of the boundary-scan test port
package scan_port_pkg;
  localparam int IR_W = 10;
  localparam int ID_W = 32;
  localparam int CFG_W = 8;
  localparam int IOSTD_W = 2;
  // Instruction codes
  localparam logic [9:0] OP_EXTEST = 10'h000;
  localparam logic [9:0] OP_CFG_LOAD = 10'h002;
  localparam logic [9:0] OP_SAMPLE = 10'h005;
  localparam logic [9:0] OP_IDCODE = 10'h006;
  localparam logic [9:0] OP_USERCODE = 10'h007;
  localparam logic [9:0] OP_CLAMP = 10'h00a;
  localparam logic [9:0] OP_HIGHZ = 10'h00b;
  localparam logic [9:0] OP_CONFIG_IO = 10'h00d;
  localparam logic [9:0] OP_LA_ACCESS = 10'h00e;
  localparam logic [9:0] OP_BYPASS = 10'h3ff;
  // Fixed pattern loaded into the instruction register at capture
  localparam logic [9:0] IR_CAPTURE = 10'h001;
  // Arbitrary identity values, not those of any real part
  localparam logic [31:0] IDCODE_RST = 32'h0000_0001;
  localparam logic [31:0] USERCODE_RST = 32'hffff_ffff;
  localparam logic [1:0] IOSTD_RST = 2'h0;
  typedef enum logic [3:0] {
    TLR = 4'b0000, RTI = 4'b0001, SEL_DR = 4'b0010, CAP_DR = 4'b0011,
    SH_DR = 4'b0100, EX1_DR = 4'b0101, PA_DR = 4'b0110, EX2_DR = 4'b0111,
    UPD_DR = 4'b1000, SEL_IR = 4'b1001, CAP_IR = 4'b1010, SH_IR = 4'b1011,
    EX1_IR = 4'b1100, PA_IR = 4'b1101, EX2_IR = 4'b1110, UPD_IR = 4'b1111
  } tap_state_t;
  // Decoded pin-drive mode in the core domain
  typedef struct packed {
    logic from_bsr;
    logic all_hiz;
  } pin_mode_t;
  // Status from the configuration engine
  typedef struct packed {
    logic power_good;
    logic busy;
    logic done;
  } cfg_status_t;
endpackage

// >>> sim/boundary_scan_test_port_properties.sv
// Concurrent checks on the test port outputs
`timescale 1ns/100ps
module boundary_scan_test_port_properties
  import scan_port_pkg::*;
#(
  parameter int NPINS = 8
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic scan_clk_in,
  input wire logic tms_in,
  input wire logic tdo_oe_n_out,
  input wire logic [NPINS-1:0] pin_out,
  input wire logic [NPINS-1:0] pin_oe_n_out,
  input wire logic [NPINS*scan_port_pkg::IOSTD_W-1:0] io_std_out,
  input wire logic [scan_port_pkg::CFG_W-1:0] cfg_byte_out,
  input wire logic cfg_valid_out,
  input wire logic cfg_abort_out
);
  reset_pins_a: assert property (@(posedge clock_in)
    rst_in |=> pin_oe_n_out == '1 && pin_out == '0) else $error("pins driven in reset");
  reset_cfg_a: assert property (@(posedge clock_in)
    rst_in |=> !cfg_valid_out && !cfg_abort_out) else $error("config flags set in reset");
  reset_iostd_a: assert property (@(posedge clock_in)
    rst_in |=> io_std_out == '0) else $error("io standard not cleared");
  valid_pulse_a: assert property (@(posedge clock_in) disable iff (rst_in)
    cfg_valid_out |=> !cfg_valid_out [*3]) else $error("byte strobe too long");
  byte_hold_a: assert property (@(posedge clock_in) disable iff (rst_in)
    $changed(cfg_byte_out) |-> cfg_valid_out) else $error("byte moved without strobe");
  abort_hold_a: assert property (@(posedge clock_in) disable iff (rst_in)
    cfg_abort_out |=> cfg_abort_out) else $error("abort dropped");
  iostd_guard_a: assert property (@(posedge clock_in) disable iff (rst_in)
    $changed(io_std_out) |-> cfg_abort_out) else $error("io standard moved");
  tdo_idle_a: assert property (@(posedge scan_clk_in) disable iff (rst_in)
    tms_in |=> tdo_oe_n_out) else $error("tdo driven outside shift");
endmodule

bind boundary_scan_test_port boundary_scan_test_port_properties #(.NPINS(NPINS)) u_props (.*);

// >>> sim/boundary_scan_test_port_test.sv
// Self-checking bench for the test port
`timescale 1ns/100ps
module boundary_scan_test_port_test;
  import scan_port_pkg::*;
  localparam int N = 8;
  logic clock_in = 0, rst_in = 1, ce_in = 1;
  logic scan_clk_in, tms_in, tdi_in, tdo_out, tdo_oe_n_out, cfg_valid_out, cfg_abort_out;
  cfg_status_t cfg_status_in = '0;
  logic [N-1:0] user_out_in = '0, user_oe_in = '0, pin_in = '0, pin_out, pin_oe_n_out;
  logic [2*N-1:0] io_std_out;
  logic [15:0] la_data_in = '0;
  logic [7:0] cfg_byte_out;
  logic [7:0] got [$];
  logic [31:0] seed = 32'h4240ffad;
  int n_fail = 0, n_tests = 0;
  always #25 clock_in = ~clock_in;
  scan_tester u_tst (.scan_clk_out(scan_clk_in), .tms_out(tms_in), .tdi_out(tdi_in), .tdo_in(tdo_out));
  boundary_scan_test_port #(.NPINS(N)) dut (.*);
  // Collect bytes handed to the config engine
  always @(posedge clock_in) if (cfg_valid_out === 1'b1) got.push_back(cfg_byte_out);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Pin drive {oe_n, value} from a boundary update word
  function automatic logic [15:0] drv(input logic [31:0] p);
    for (int i = 0; i < N; i++) begin
      drv[i] = p[3*i+1];
      drv[N+i] = !p[3*i+2];
    end
  endfunction
  task automatic rnd(output logic [31:0] r);
    seed = lfsr(seed);
    r = seed;
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    logic [31:0] o, d, r, p;
    logic [9:0] codes [4];
    fork
      u_tst.tlr(8);
      begin
        repeat (3) @(posedge clock_in);
        rst_in <= 1'b0;
      end
    join
    u_tst.tlr(6);
    rnd(r);
    @(posedge clock_in) begin
      user_out_in <= r[7:0];
      user_oe_in <= r[15:8] | 8'h01;
      pin_in <= r[23:16];
      la_data_in <= r[31:16];
    end
    pause(6);
    check("unpowered oe_n", pin_oe_n_out, 8'hff);
    @(posedge clock_in) cfg_status_in <= 3'b101;
    pause(8);
    check("user oe_n", pin_oe_n_out, N'(~user_oe_in));
    u_tst.scan(0, 32, 0, o);
    check("idcode", o, IDCODE_RST);
    check("id lsb", o[0], 1'b1);
    check("tdo idle", tdo_oe_n_out, 1'b1);
    u_tst.scan(1, 10, OP_USERCODE, o);
    check("ir capture", o[9:0], IR_CAPTURE);
    u_tst.scan(0, 32, 0, o);
    check("usercode", o, USERCODE_RST);
    u_tst.scan(1, 10, OP_SAMPLE, o);
    rnd(p);
    u_tst.scan(0, 24, p, o);
    check("sample", o[23:0], {pin_in, user_out_in, user_oe_in});
    pause(8);
    check("sample oe_n", pin_oe_n_out, N'(~user_oe_in));
    u_tst.scan(1, 10, OP_EXTEST, o);
    pause(8);
    check("extest pins", {pin_oe_n_out, pin_out}, drv(p));
    u_tst.scan(0, 24, p, o);
    check("extest capture", o[23:16], pin_in);
    @(posedge clock_in) cfg_status_in <= 3'b110;
    u_tst.scan(1, 10, OP_SAMPLE, o);
    u_tst.scan(1, 10, OP_EXTEST, o);
    pause(8);
    check("busy oe_n", pin_oe_n_out, 8'hff);
    @(posedge clock_in) cfg_status_in <= 3'b101;
    rnd(r);
    codes = '{OP_CLAMP, OP_HIGHZ, OP_BYPASS, 10'h3c0 | r[5:0]};
    foreach (codes[i]) begin
      u_tst.scan(1, 10, codes[i], o);
      pause(8);
      if (i == 0) check("clamp pins", {pin_oe_n_out, pin_out}, drv(p));
      if (i == 1) check("highz oe_n", pin_oe_n_out, 8'hff);
      rnd(d);
      u_tst.scan(0, 16, d, o);
      check("bypass", o[15:0], {d[14:0], 1'b0});
    end
    u_tst.scan(1, 10, OP_LA_ACCESS, o);
    u_tst.scan(0, 16, 0, o);
    check("probe", o[15:0], la_data_in);
    u_tst.scan(1, 10, OP_CFG_LOAD, o);
    rnd(d);
    u_tst.scan(0, 16, d, o);
    pause(10);
    check("byte count", got.size(), 2);
    check("bytes", {got[1], got[0]}, d[15:0]);
    u_tst.scan(1, 10, OP_CONFIG_IO, o);
    rnd(d);
    u_tst.scan(0, 16, d, o);
    pause(8);
    check("io std", io_std_out, d[15:0]);
    check("abort", cfg_abort_out, 1'b1);
    @(posedge clock_in) begin
      ce_in <= 1'b0;
      cfg_status_in <= '0;
    end
    pause(4);
    check("frozen oe_n", pin_oe_n_out, N'(~user_oe_in));
    @(posedge clock_in) ce_in <= 1'b1;
    pause(2);
    check("unfrozen oe_n", pin_oe_n_out, 8'hff);
    stop_test;
  end
  // Watchdog
  initial begin
    #300000;
    n_fail++;
    stop_test;
  end
endmodule

// >>> sim/scan_tester.sv
// Behavioural test controller on the scan link
`timescale 1ns/100ps
module scan_tester (
  output logic scan_clk_out,
  output logic tms_out,
  output logic tdi_out,
  input wire logic tdo_in
);
  // Clock stands still between frames
  initial begin
    scan_clk_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
  end
  // One 30 ns clock; lines change while low, tdo taken at the rise
  task automatic tick(input logic m, input logic d, output logic q);
    tms_out = m;
    tdi_out = d;
    #15 scan_clk_out = 1'b1;
    q = tdo_in;
    #15 scan_clk_out = 1'b0;
  endtask
  task automatic tlr(input int k);
    logic q;
    repeat (k) tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask
  task automatic scan(input bit ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic q;
    dout = '0;
    tick(1'b1, 1'b0, q);
    if (ir) tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tick(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], q);
      dout[i] = q;
    end
    tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask
endmodule
